// [ssr_defines.svh]
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// frame layout
`define SSR_FRAME_W       16
`define SSR_ADDR_HI       15
`define SSR_ADDR_LO       14
`define SSR_RSEL_BIT      13
`define SSR_NOWR_BIT      12
`define SSR_ADDR_STATUS   2'h0
`define SSR_DATA_HI       11
// status word fields
`define SSR_CAUSE_HI      11
`define SSR_CAUSE_LO      8
`define SSR_CANW_BIT      7
`define SSR_LINW_BIT      6
`define SSR_EDGE_BIT      5
`define SSR_LEVEL_BIT     4
`define SSR_TEMP_BIT      3
`define SSR_SDM_BIT       2
`define SSR_ENS_BIT       1
`define SSR_PWON_BIT      0
// reset cause codes
`define SSR_RC_POWERON    4'h0
`define SSR_RC_CYCLIC     4'h1
`define SSR_RC_SUPPLY_LOW 4'h2
`define SSR_RC_SUPPLY_OC  4'h3
`define SSR_RC_SWBAT_OVL  4'h4
`define SSR_RC_FLASH_EXIT 4'h5
`define SSR_RC_FLASH_RDY  4'h6
`define SSR_RC_CAN_WAKE   4'h7
`define SSR_RC_LIN_WAKE   4'h8
`define SSR_RC_LOCAL_WAKE 4'h9
`define SSR_RC_FAILSAFE   4'hA
`define SSR_RC_WD_OVF     4'hB
`define SSR_RC_WD_INIT    4'hC
`define SSR_RC_WD_EARLY   4'hD
`define SSR_RC_SPI_ILL    4'hE
`define SSR_RC_INT_TMO    4'hF
`define SSR_CNT_W         5
`define SSR_LAST_BIT      5'h0F

`endif

// [ssr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
    // serial link
    output logic            linkClk,
    output logic            linkCsN,
    output logic            linkMosi,
    input  wire logic       linkMiso
);
    initial begin
        linkClk = 1'b0;
        linkCsN = 1'b1;
        linkMosi = 1'b0;
    end
    // clock stands still between frames; short frames model aborts
    task automatic frame(input logic [15:0] tx, input int edges, output logic [15:0] rx);
        rx = 16'h0000;
        linkCsN = 1'b0;
        linkMosi = tx[15];
        #32;
        for (int i = 15; i > 15 - edges; i--) begin
            linkClk = 1'b1;
            #32;
            linkClk = 1'b0;
            #16;
            rx[i] = linkMiso;
            if (i > 0) linkMosi = tx[i - 1];
            #16;
        end
        linkCsN = 1'b1;
        linkMosi = ~linkMosi; // released line must not show a stale bit
        #400;
    endtask : frame
endmodule : ssr_host_model
`default_nettype wire

// [ssr_pkg.sv]
package ssr_pkg;

    // reset causes, one-hot request vector index order
    typedef enum logic [3:0] {
        RC_POWERON    = 4'h0,
        RC_CYCLIC     = 4'h1,
        RC_SUPPLY_LOW = 4'h2,
        RC_SUPPLY_OC  = 4'h3,
        RC_SWBAT_OVL  = 4'h4,
        RC_FLASH_EXIT = 4'h5,
        RC_FLASH_RDY  = 4'h6,
        RC_CAN_WAKE   = 4'h7,
        RC_LIN_WAKE   = 4'h8,
        RC_LOCAL_WAKE = 4'h9,
        RC_FAILSAFE   = 4'hA,
        RC_WD_OVF     = 4'hB,
        RC_WD_INIT    = 4'hC,
        RC_WD_EARLY   = 4'hD,
        RC_SPI_ILL    = 4'hE,
        RC_INT_TMO    = 4'hF
    } ssr_cause_t;

    typedef enum logic [1:0] {
        LK_IDLE  = 2'b00,
        LK_SHIFT = 2'b01,
        LK_DONE  = 2'b10
    } ssr_link_state_t;

    // state on the serial clock
    typedef struct packed {
        ssr_link_state_t lkState;
        logic [4:0]      bitCnt;
        logic [15:0]     rxShift;
        logic [15:0]     txShift;
        logic            misoBit;
        logic            doneTgl;
        logic [15:0]     frame;
    } ssr_link_t;

    // state on the system clock
    typedef struct packed {
        logic [2:0]  doneSync;
        logic [2:0]  csSync;
        logic [2:0]  wakeSync;
        logic [1:0]  tempSync;
        logic [3:0]  cause;
        logic        canWake;
        logic        linWake;
        logic        edgeWake;
        logic        powerUp;
        logic [15:0] snap;
        logic        modeWrStb;
        logic [11:0] modeData;
        logic        diagSel;
    } ssr_sys_t;

endpackage : ssr_pkg

// [ssr_status_readback.sv]
`include "ssr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ssr_status_readback (
    // system clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // serial link, frame clocked by the host
    input  wire logic        linkClk,
    input  wire logic        linkCsN,
    input  wire logic        linkMosi,
    output logic             linkMiso,
    // reset events, one bit per cause code, same clock
    input  wire logic [15:0] resetCauseReq,
    // wake events, same clock, one-cycle pulses
    input  wire logic        canWakeEvt,
    input  wire logic        linWakeEvt,
    // asynchronous levels from pins and analog
    input  wire logic        localWakePin,
    input  wire logic        overheatWarning,
    // device state, same clock
    input  wire logic        swDevModeFlag,
    input  wire logic        safetyOutputState,
    input  wire logic        powerOnRst,
    input  wire logic        normalModeEntered,
    // diagnosis word supplied by neighbouring logic
    input  wire logic [11:0] diagWord,
    // mode register write and diagnosis read notice
    output logic             modeWrStb,
    output logic [11:0]      modeWrData,
    output logic             diagReadStb
);

    ssr_pkg::ssr_sys_t  s_q, s_d;
    ssr_pkg::ssr_link_t l_q, l_d;

    // reset of the link domain: chip select high is the idle, link clock
    // may stop outside frames so state is reset by the frame edge
    logic lkRst;
    assign lkRst = linkCsN;

    function automatic logic isStatusFrame(input logic [15:0] f);
        isStatusFrame = (f[`SSR_ADDR_HI:`SSR_ADDR_LO] == `SSR_ADDR_STATUS)
                        && !f[`SSR_RSEL_BIT];
    endfunction : isStatusFrame

    function automatic logic isDiagFrame(input logic [15:0] f);
        isDiagFrame = (f[`SSR_ADDR_HI:`SSR_ADDR_LO] == `SSR_ADDR_STATUS)
                      && f[`SSR_RSEL_BIT];
    endfunction : isDiagFrame

    // highest requested cause wins when several arrive together
    function automatic logic [3:0] pickCause(input logic [15:0] req,
                                             input logic [3:0]  keep);
        logic [3:0] c;
        c = keep;
        for (int i = 0; i < 16; i++) begin
            if (req[i]) begin
                c = 4'(i);
            end
        end
        pickCause = c;
    endfunction : pickCause

    // live word, built on system clock; snapshot passes to link domain
    logic [15:0] liveWord;
    logic        localLvl;
    logic        tempLvl;
    logic        frameDone;
    logic        frameOpen;
    assign localLvl  = s_q.wakeSync[1];
    assign tempLvl   = s_q.tempSync[1];
    // full flag drops when chip select releases a complete frame;
    // the frame register is steady by then, so reading it is safe
    assign frameDone = s_q.doneSync[2] && !s_q.doneSync[1];
    assign frameOpen = !s_q.csSync[1];

    always_comb begin
        liveWord = 16'h0000;
        liveWord[`SSR_CAUSE_HI:`SSR_CAUSE_LO] = s_q.cause;
        liveWord[`SSR_CANW_BIT]  = s_q.canWake;
        liveWord[`SSR_LINW_BIT]  = s_q.linWake;
        liveWord[`SSR_EDGE_BIT]  = s_q.edgeWake;
        liveWord[`SSR_LEVEL_BIT] = localLvl;
        liveWord[`SSR_TEMP_BIT]  = tempLvl;
        liveWord[`SSR_SDM_BIT]   = swDevModeFlag;
        liveWord[`SSR_ENS_BIT]   = safetyOutputState;
        liveWord[`SSR_PWON_BIT]  = s_q.powerUp;
    end

    always_comb begin
        logic statusRd;
        logic diagRd;
        logic wrMode;
        statusRd = 1'b0;
        diagRd   = 1'b0;
        wrMode   = 1'b0;
        s_d = s_q;
        s_d.doneSync  = {s_q.doneSync[1:0], l_q.doneTgl};
        s_d.csSync    = {s_q.csSync[1:0], linkCsN};
        s_d.wakeSync  = {s_q.wakeSync[1:0], localWakePin};
        s_d.tempSync  = {s_q.tempSync[0], overheatWarning};
        s_d.modeWrStb = 1'b0;
        s_d.diagSel   = s_q.diagSel;
        if (frameDone) begin
            // no mode gating on the read path
            statusRd = isStatusFrame(l_q.frame);
            diagRd   = isDiagFrame(l_q.frame);
            wrMode   = (statusRd || diagRd)
                       && !l_q.frame[`SSR_NOWR_BIT];
        end
        if (wrMode) begin
            s_d.modeWrStb = 1'b1;
            s_d.modeData  = l_q.frame[`SSR_DATA_HI:0];
        end
        // hold the snapshot while a frame is open so it does not tear
        if (!frameOpen) begin
            s_d.snap = liveWord;
        end
        s_d.cause = pickCause(resetCauseReq, s_q.cause);
        // set wins over clear; clear only after a whole status frame
        if (statusRd) begin
            s_d.canWake  = 1'b0;
            s_d.linWake  = 1'b0;
            s_d.edgeWake = 1'b0;
        end
        if (canWakeEvt) begin
            s_d.canWake = 1'b1;
        end
        if (linWakeEvt) begin
            s_d.linWake = 1'b1;
        end
        if (s_q.wakeSync[2] && !s_q.wakeSync[1]) begin
            s_d.edgeWake = 1'b1;
        end
        if (normalModeEntered) begin
            s_d.powerUp = 1'b0;
        end
        if (powerOnRst) begin
            s_d.powerUp = 1'b1;
        end
        s_d.diagSel = diagRd;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q          <= '0;
            s_q.csSync   <= 3'b111;
            s_q.cause    <= `SSR_RC_POWERON;
            s_q.powerUp  <= 1'b1;
            s_q.wakeSync <= 3'b111;
        end else begin
            s_q <= s_d;
        end
    end

    // link side: snapshot is stable across the whole frame, so
    // sampling it here at the first edge is a safe word crossing
    logic [15:0] txWord;
    always_comb begin
        txWord = s_q.snap;
    end

    always_comb begin
        l_d = l_q;
        case (l_q.lkState)
            ssr_pkg::LK_IDLE: begin
                l_d.rxShift = {l_q.rxShift[14:0], linkMosi};
                l_d.bitCnt  = 5'h01;
                l_d.txShift = {txWord[14:0], 1'b0};
                l_d.misoBit = txWord[15];
                l_d.lkState = ssr_pkg::LK_SHIFT;
            end
            ssr_pkg::LK_SHIFT: begin
                l_d.rxShift = {l_q.rxShift[14:0], linkMosi};
                l_d.misoBit = l_q.txShift[15];
                l_d.txShift = {l_q.txShift[14:0], 1'b0};
                l_d.bitCnt  = l_q.bitCnt + 5'h01;
                if (l_q.bitCnt == `SSR_LAST_BIT) begin
                    // frame counted complete only at sixteen bits
                    l_d.frame   = {l_q.rxShift[14:0], linkMosi};
                    l_d.doneTgl = 1'b1;
                    l_d.lkState = ssr_pkg::LK_DONE;
                end
            end
            ssr_pkg::LK_DONE: begin
                // extra clocks are ignored; the first sixteen bits still count as the frame
                l_d.lkState = ssr_pkg::LK_DONE;
            end
            default: begin
                l_d.lkState = ssr_pkg::LK_IDLE;
            end
        endcase
    end

    // miso updates on falling edge of the link clock
    always_ff @(posedge linkClk or posedge lkRst) begin
        if (lkRst) begin
            l_q.lkState <= ssr_pkg::LK_IDLE;
            l_q.bitCnt  <= 5'h00;
            l_q.rxShift <= 16'h0000;
            l_q.txShift <= 16'h0000;
            l_q.misoBit <= 1'b0;
            l_q.doneTgl <= 1'b0;
        end else begin
            l_q.lkState <= l_d.lkState;
            l_q.bitCnt  <= l_d.bitCnt;
            l_q.rxShift <= l_d.rxShift;
            l_q.txShift <= l_d.txShift;
            l_q.misoBit <= l_d.misoBit;
            l_q.doneTgl <= l_d.doneTgl;
            // frame has no reset: it must outlive chip select release
            l_q.frame   <= l_d.frame;
        end
    end

    logic misoQ;
    always_ff @(negedge linkClk or posedge lkRst) begin
        if (lkRst) begin
            misoQ <= 1'b0;
        end else begin
            misoQ <= l_q.misoBit;
        end
    end

    assign linkMiso    = misoQ;
    assign modeWrStb   = s_q.modeWrStb;
    assign modeWrData  = s_q.modeData;
    assign diagReadStb = s_q.diagSel;

endmodule : ssr_status_readback

`default_nettype wire

// [ssr_status_readback_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_status_readback_chk (
    // system side
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        linkCsN,
    // strobes
    input wire logic        modeWrStb,
    input wire logic [11:0] modeWrData,
    input wire logic        diagReadStb
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // strobe only once the frame is closed and stays closed
    sequence frameClosed;
        linkCsN && $past(linkCsN, 2);
    endsequence
    chk_mode_one_pulse: assert property (modeWrStb |=> !modeWrStb [*8])
        else $error("mode strobe too long");
    chk_diag_one_pulse: assert property (diagReadStb |=> !diagReadStb [*8])
        else $error("diag strobe too long");
    chk_mode_after_frame: assert property (modeWrStb |-> frameClosed)
        else $error("mode strobe inside frame");
    chk_diag_after_frame: assert property (diagReadStb |-> frameClosed)
        else $error("diag strobe inside frame");
    chk_mode_data_hold: assert property ($changed(modeWrData) |-> modeWrStb)
        else $error("mode data moved without strobe");
    chk_csn_gap_mode: assert property (modeWrStb |-> $past(linkCsN, 1))
        else $error("mode strobe right after frame edge");
    chk_mode_reset: assert property (disable iff (1'b0) sys_rst |=> !modeWrStb)
        else $error("mode strobe during reset");
    chk_diag_reset: assert property (disable iff (1'b0) sys_rst |=> !diagReadStb)
        else $error("diag strobe during reset");
endmodule : ssr_status_readback_chk
`default_nettype wire

// [ssr_status_readback_test.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_status_readback_test;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        linkClk, linkCsN, linkMosi, linkMiso;
    logic [15:0] resetCauseReq = 16'h0000;
    logic        canWakeEvt = 1'b0, linWakeEvt = 1'b0, localWakePin = 1'b1;
    logic        overheatWarning = 1'b0, swDevModeFlag = 1'b0, safetyOutputState = 1'b0;
    logic        powerOnRst = 1'b0, normalModeEntered = 1'b0;
    logic        modeWrStb, diagReadStb;
    logic [11:0] modeWrData, modeSeen = 12'h000;
    logic [15:0] rx, modeCnt = 16'h0000, diagCnt = 16'h0000;
    int          errors = 0, comparisons = 0;

    always #10 clk_sys = ~clk_sys;

    ssr_host_model u_ssr_host_model (.linkClk(linkClk), .linkCsN(linkCsN),
        .linkMosi(linkMosi), .linkMiso(linkMiso));

    ssr_status_readback u_ssr_status_readback (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk), .linkCsN(linkCsN),
        .linkMosi(linkMosi), .linkMiso(linkMiso), .resetCauseReq(resetCauseReq),
        .canWakeEvt(canWakeEvt), .linWakeEvt(linWakeEvt), .localWakePin(localWakePin),
        .overheatWarning(overheatWarning), .swDevModeFlag(swDevModeFlag),
        .safetyOutputState(safetyOutputState), .powerOnRst(powerOnRst),
        .normalModeEntered(normalModeEntered), .diagWord(12'h5A3),
        .modeWrStb(modeWrStb), .modeWrData(modeWrData), .diagReadStb(diagReadStb));

    always @(posedge clk_sys) begin
        if (modeWrStb === 1'b1) begin
            modeCnt++;
            modeSeen = modeWrData;
        end
        if (diagReadStb === 1'b1) diagCnt++;
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task print_verdict;
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // one-cycle event pulses, then time for sync and snapshot
    task automatic strobe(input logic [15:0] cause, input logic can, lin, pon, nrm);
        @(posedge clk_sys);
        resetCauseReq <= cause;
        canWakeEvt <= can;
        linWakeEvt <= lin;
        powerOnRst <= pon;
        normalModeEntered <= nrm;
        @(posedge clk_sys);
        resetCauseReq <= 16'h0000;
        {canWakeEvt, linWakeEvt, powerOnRst, normalModeEntered} <= 4'h0;
        repeat (6) @(posedge clk_sys);
    endtask : strobe

    task automatic rd(input logic [15:0] tx, input logic [11:0] exp, input string name);
        u_ssr_host_model.frame(tx, 16, rx);
        check(name, {4'h0, exp}, {4'h0, rx[11:0]});
    endtask : rd

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        print_verdict;
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(16'h1000, 12'h011, "status after reset");
        for (int c = 0; c < 16; c++) begin
            strobe(16'h0001 << c, 1'b0, 1'b0, 1'b0, 1'b0);
            u_ssr_host_model.frame(16'h1000, 16, rx);
            check("reset cause", 16'(c), {12'h000, rx[11:8]});
        end
        @(posedge clk_sys);
        {localWakePin, overheatWarning, swDevModeFlag, safetyOutputState} <= 4'h7;
        strobe(16'h0000, 1'b1, 1'b1, 1'b0, 1'b1);
        rd(16'h0A5C, 12'hFEE, "status with wakes");
        check("mode writes", 16'h0001, modeCnt);
        check("mode data", 16'h0A5C, {4'h0, modeSeen});
        rd(16'h1000, 12'hF0E, "flags cleared");
        check("mode writes", 16'h0001, modeCnt);
        strobe(16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
        u_ssr_host_model.frame(16'h1000, 8, rx);
        rd(16'h1000, 12'hF8E, "flag after short frame");
        u_ssr_host_model.frame(16'h3000, 16, rx);
        check("diag reads", 16'h0001, diagCnt);
        check("mode writes", 16'h0001, modeCnt);
        strobe(16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
        u_ssr_host_model.frame(16'h1000, 16, rx);
        check("power-up flag", 16'h0001, {15'h0000, rx[0]});
        print_verdict;
    end
endmodule : ssr_status_readback_test

bind ssr_status_readback ssr_status_readback_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .linkCsN(linkCsN), .modeWrStb(modeWrStb), .modeWrData(modeWrData),
    .diagReadStb(diagReadStb));
`default_nettype wire
